// File: core/phm_host_port.sv
// Host management port of the PHY with negotiation status and debug timer.
// Notes on behaviour
// R01: Low level on the reset input resets everything, management port included.
// R02: Negotiation-done output high when negotiation finished, low otherwise.
// R03: Debug short-timer input high makes the link timer run much faster.
// R04: All management bus logic is clocked by the host bus clock.
// R05: Select low starts a transfer; bus ignored while select is high.
// R06: Write strobe low writes the addressed register, except the read-only status register; high means read.
// R07: Six-bit address picks exactly one management register.
// R08: Write data comes from the eight-bit write-data bus.
// R09: Read data returns on a separate eight-bit read-data bus.
// R10: On writes, ready goes low only after data is stored.
// R11: On reads, ready goes low only once read data is valid.
// R12: Host holds inputs stable until ready, then releases select.
`timescale 1ns/1ps
module phm_host_port #(
	parameter int LINK_CYCLES_P  = phm_pkg::LINK_CYCLES,
	parameter int SHORT_CYCLES_P = phm_pkg::LINK_CYCLES_SHORT
) (
	input  wire logic                      CLOCK,
	input  wire logic                      RST_N,
	input  wire logic                      HCS_N,
	input  wire logic                      HWRITE_N,
	input  wire logic [phm_pkg::ADDR_W-1:0] HADDR,
	input  wire logic [phm_pkg::DATA_W-1:0] HDATAIN,
	input  wire logic                      DEBUG_LINK_TIMER_SHORT,
	output logic      [phm_pkg::DATA_W-1:0] HDATAOUT,
	output logic                           HREADY_N,
	output logic                           NEGOTIATION_DONE
);
	import phm_pkg::*;

	// The decode and the status byte assume the fixed bus widths
	if (ADDR_W != 6 || DATA_W != 8) begin : g_bad_widths
		$error("phm_host_port: bus widths must be 6 and 8");
	end

	typedef struct packed {
		phm_bus_state_t    state;
		logic [DATA_W-1:0] rdata;
		logic              ready_n;
		logic              done;
		logic              restart;
	} phm_st_t;

	phm_st_t           st_ff;
	phm_st_t           nxt_st;
	logic [DATA_W-1:0] regs_ff [NUM_REGS];
	phm_req_t          req;
	logic              tmr_expired;
	logic              wr_en;
	logic [DATA_W-1:0] status_val;

	// Address decode used by both the write path and the read mux
	function automatic logic is_status(input logic [ADDR_W-1:0] a);
		return a == REG_STATUS_IDX;
	endfunction

	assign req = '{cs_n: HCS_N, write_n: HWRITE_N, addr: HADDR, wdata: HDATAIN};

	// ****************************************************************
	// Link timer
	// ****************************************************************
	phm_link_timer #(
		.NORMAL_CYCLES (LINK_CYCLES_P),
		.SHORT_CYCLES  (SHORT_CYCLES_P)
	) u_timer (
		.clk        (CLOCK),
		.rst_n      (RST_N),
		.restart    (st_ff.restart),
		.short_mode (DEBUG_LINK_TIMER_SHORT), // [R03]
		.expired    (tmr_expired)
	);

	// Status byte: done flag and current timer mode
	always_comb begin
		status_val = '0;
		status_val[STAT_DONE_BIT]  = st_ff.done;
		status_val[STAT_SHORT_BIT] = DEBUG_LINK_TIMER_SHORT;
	end

	// ****************************************************************
	// Bus state machine
	// ****************************************************************
	// One wait cycle before ready so write lands and read data is settled
	always_comb begin
		nxt_st = st_ff;
		wr_en = 1'h0;
		nxt_st.restart = 1'h0;
		nxt_st.done = tmr_expired && !st_ff.restart; // [R02]
		unique case (st_ff.state)
			PHM_IDLE: begin
				nxt_st.ready_n = 1'h1;
				if (!req.cs_n) begin // [R05]
					nxt_st.state = PHM_BUSY;
					if (!req.write_n) begin // [R06]
						wr_en = !is_status(req.addr); // [R07]
						if (req.addr == REG_CTRL_IDX && req.wdata[CTRL_RESTART_BIT])
							nxt_st.restart = 1'h1;
					end else begin
						nxt_st.rdata = is_status(req.addr) ? status_val
						                                   : regs_ff[req.addr]; // [R09]
					end
				end
			end
			PHM_BUSY: begin
				// Data is in place now, so ready may be shown
				nxt_st.ready_n = 1'h0; // [R10] [R11]
				nxt_st.state = PHM_DONE;
			end
			PHM_DONE: begin
				// Hold ready until select goes away, so one transfer per select
				if (req.cs_n) begin // [R12]
					nxt_st.ready_n = 1'h1;
					nxt_st.state = PHM_IDLE;
				end
			end
			default: begin
				nxt_st.state = PHM_IDLE;
				nxt_st.ready_n = 1'h1;
			end
		endcase
	end

	// Registers clocked by the host clock only
	always_ff @(posedge CLOCK) begin // [R04]
		if (!RST_N) begin
			st_ff <= '{state: PHM_IDLE, rdata: '0, ready_n: 1'h1,
			           done: 1'h0, restart: 1'h1}; // [R01]
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Register array; the restart bit is stored as written, only the restart pulse self-clears
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_ff[i] <= REG_RESET_VAL; // [R01]
		end else if (wr_en) begin
			regs_ff[req.addr] <= req.wdata; // [R08]
		end
	end

	assign HDATAOUT = st_ff.rdata;
	assign HREADY_N = st_ff.ready_n;
	assign NEGOTIATION_DONE = st_ff.done;

endmodule // phm_host_port

// File: common/phm_pkg.sv
// Package for the PHY host management port: widths, register map, timer counts.
package phm_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 64;

	// ****************************************************************
	// Register map (indices into the management register array)
	// ****************************************************************
	localparam logic [5:0] REG_CTRL_IDX   = 6'h00; // Bit 0 restarts negotiation
	localparam logic [5:0] REG_STATUS_IDX = 6'h01; // Read only status
	localparam int CTRL_RESTART_BIT = 0;
	localparam int STAT_DONE_BIT    = 0;
	localparam int STAT_SHORT_BIT   = 1;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS     = 50;
	localparam int LINK_TIME_NS      = 10000000; // Normal link timer, 10 ms
	localparam int LINK_TIME_SHORT_NS = 2000;    // Debug link timer, 2 us
	localparam int LINK_CYCLES       = LINK_TIME_NS / CLK_PERIOD_NS;
	localparam int LINK_CYCLES_SHORT = LINK_TIME_SHORT_NS / CLK_PERIOD_NS;
	localparam int TIMER_W           = 18;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		PHM_IDLE = 2'h0,
		PHM_BUSY = 2'h1,
		PHM_DONE = 2'h3
	} phm_bus_state_t;

	typedef struct packed {
		logic              cs_n;
		logic              write_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} phm_req_t;

endpackage

// File: core/phm_link_timer.sv
// Auto-negotiation link timer with a debug short mode.
`timescale 1ns/1ps
module phm_link_timer #(
	parameter int NORMAL_CYCLES = phm_pkg::LINK_CYCLES,
	parameter int SHORT_CYCLES  = phm_pkg::LINK_CYCLES_SHORT
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic restart,
	input  wire logic short_mode,
	output logic      expired
);
	import phm_pkg::*;

	// Both limits must fit the counter, or the truncated limit would end the count early
	if (NORMAL_CYCLES < 1 || SHORT_CYCLES < 1 ||
		NORMAL_CYCLES >= (1 << TIMER_W) || SHORT_CYCLES >= (1 << TIMER_W)) begin : g_bad_counts
		$error("phm_link_timer: cycle counts out of range");
	end

	typedef struct packed {
		logic [TIMER_W-1:0] cnt;
		logic               expired;
	} phm_tmr_st_t;

	phm_tmr_st_t st_ff;
	phm_tmr_st_t nxt_st;
	logic [TIMER_W-1:0] limit;

	// ****************************************************************
	// Counter
	// ****************************************************************
	// Short limit picked live so the debug pin takes effect at once
	always_comb begin
		limit = short_mode ? TIMER_W'(SHORT_CYCLES - 1)
		                   : TIMER_W'(NORMAL_CYCLES - 1); // [R03]
		nxt_st = st_ff;
		if (restart) begin
			nxt_st.cnt = '0;
			nxt_st.expired = 1'h0;
		end else if (!st_ff.expired) begin
			if (st_ff.cnt >= limit)
				nxt_st.expired = 1'h1;
			else
				nxt_st.cnt = st_ff.cnt + TIMER_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			st_ff <= '0; // [R01]
		else
			st_ff <= nxt_st;
	end

	assign expired = st_ff.expired;

endmodule // phm_link_timer

// File: testbench/phm_host_port_asserts.sv
// Checker for the host management port.
`timescale 1ns/1ps
module phm_host_port_asserts #(
	parameter int LINK_CYCLES_P  = phm_pkg::LINK_CYCLES,
	parameter int SHORT_CYCLES_P = phm_pkg::LINK_CYCLES_SHORT
) (
	input wire logic       CLOCK,
	input wire logic       RST_N,
	input wire logic       HCS_N,
	input wire logic       HWRITE_N,
	input wire logic [5:0] HADDR,
	input wire logic [7:0] HDATAIN,
	input wire logic       DEBUG_LINK_TIMER_SHORT,
	input wire logic [7:0] HDATAOUT,
	input wire logic       HREADY_N,
	input wire logic       NEGOTIATION_DONE
);
	localparam int SMAX = SHORT_CYCLES_P + 4;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// Reset must win over everything, so this one is never disabled
	rst_values_a:
		assert property (disable iff (1'h0) !RST_N |=> HREADY_N && HDATAOUT == 8'h00
			&& !NEGOTIATION_DONE) else $error("outputs not reset");
	idle_quiet_a:
		assert property (HCS_N && HREADY_N |=> HREADY_N) else $error("ready while idle");
	ready_latency_a:
		assert property ($fell(HCS_N) && HREADY_N |=> HREADY_N ##1 !HREADY_N)
		else $error("ready latency wrong");
	ready_hold_a:
		assert property (!HREADY_N && !HCS_N |=> !HREADY_N) else $error("ready dropped");
	ready_release_a:
		assert property (!HREADY_N && HCS_N |=> HREADY_N) else $error("ready stuck");
	write_keeps_a:
		assert property ($fell(HCS_N) && HREADY_N && !HWRITE_N |=> $stable(HDATAOUT) [*2])
		else $error("write moved read data");
	short_timer_a:
		assert property ($rose(RST_N) && DEBUG_LINK_TIMER_SHORT |-> ##[1:SMAX] NEGOTIATION_DONE)
		else $error("short timer slow");
	normal_timer_a:
		assert property ($rose(RST_N) && !DEBUG_LINK_TIMER_SHORT |-> !NEGOTIATION_DONE [*8])
		else $error("done too early");
endmodule // phm_host_port_asserts

bind phm_host_port phm_host_port_asserts #(.LINK_CYCLES_P(LINK_CYCLES_P),
	.SHORT_CYCLES_P(SHORT_CYCLES_P)) i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .HCS_N(HCS_N),
	.HWRITE_N(HWRITE_N), .HADDR(HADDR), .HDATAIN(HDATAIN),
	.DEBUG_LINK_TIMER_SHORT(DEBUG_LINK_TIMER_SHORT), .HDATAOUT(HDATAOUT),
	.HREADY_N(HREADY_N), .NEGOTIATION_DONE(NEGOTIATION_DONE));

// File: testbench/phm_host_model.sv
// Host CPU model on the management bus.
`timescale 1ns/1ps
module phm_host_model (
	input  wire logic          CLOCK,
	input  wire logic          HREADY_N,
	input  wire logic [7:0]    HDATAOUT,
	output phm_pkg::phm_req_t  req
);
	import phm_pkg::*;
	initial req = '{1'h1, 1'h1, 6'h00, 8'h00};
	// One transfer; lines hold until ready is sampled low
	task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q, output bit ok);
		ok = 0;
		@(posedge CLOCK);
		#1 req = '{1'h0, w, a, d};
		for (int i = 0; i < 10 && !ok; i++) begin
			@(posedge CLOCK);
			#1 ok = (HREADY_N === 1'h0);
		end
		@(posedge CLOCK);
		#1 q = HDATAOUT;
		// Inverse on release so no stale value can pass for a live one
		req = ~req;
	endtask
endmodule // phm_host_model

// File: testbench/phm_host_port_tb.sv
// Self-checking bench for the host management port.
`timescale 1ns/1ps
module phm_host_port_tb;
	import phm_pkg::*;
	typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [7:0] e;} phm_row_t;
	logic       clock = 1'h0;
	logic       rst_n = 1'h0;
	logic       dbg_short = 1'h0;
	phm_req_t   req;
	logic [7:0] rdata;
	logic       rdy_n;
	logic       done;
	logic [7:0] q;
	bit         ok;
	int         mismatches = 0;
	int         checked = 0;
	// Writes expect the last read value to stay on the read bus
	phm_row_t   rows [8] = '{'{1'h0, 6'h02, 8'hA5, 8'h00}, '{1'h0, 6'h3F, 8'h5A, 8'h00},
		'{1'h1, 6'h02, 8'h00, 8'hA5}, '{1'h1, 6'h3F, 8'h00, 8'h5A}, '{1'h1, 6'h10, 8'h00, 8'h00},
		'{1'h0, 6'h10, 8'h3C, 8'h00}, '{1'h1, 6'h10, 8'h00, 8'h3C}, '{1'h0, 6'h01, 8'hFF, 8'h3C}};
	always #25 clock = ~clock;
	phm_host_port #(.LINK_CYCLES_P(20), .SHORT_CYCLES_P(4)) i_dut (.CLOCK(clock),
		.RST_N(rst_n), .HCS_N(req.cs_n), .HWRITE_N(req.write_n), .HADDR(req.addr),
		.HDATAIN(req.wdata), .DEBUG_LINK_TIMER_SHORT(dbg_short), .HDATAOUT(rdata),
		.HREADY_N(rdy_n), .NEGOTIATION_DONE(done));
	phm_host_model i_host (.CLOCK(clock), .HREADY_N(rdy_n), .HDATAOUT(rdata), .req(req));
	task automatic complete_run;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic w, input logic [5:0] a, input logic [7:0] d, e);
		i_host.xfer(w, a, d, q, ok);
		check({9'h000, ok}, 10'h001);
		if (!ok)
			complete_run();
		check({2'h0, q}, {2'h0, e});
	endtask
	task automatic do_reset(input logic s);
		rst_n = 1'h0;
		dbg_short = s;
		repeat (2) @(posedge clock);
		#1 rst_n = 1'h1;
	endtask
	// Bounded wait for negotiation to finish
	task automatic wait_done;
		int n = 0;
		while (done !== 1'h1 && n < 60) begin
			@(posedge clock);
			#1 n++;
		end
		check({9'h000, done}, 10'h001);
		if (done !== 1'h1)
			complete_run();
	endtask
	initial begin
		do_reset(1'h0);
		check({rdy_n, done, rdata}, 10'h200);
		foreach (rows[i])
			run(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
		wait_done();
		run(1'h1, 6'h01, 8'h00, 8'h01);
		run(1'h0, 6'h00, 8'h01, 8'h01);
		check({9'h000, done}, 10'h000);
		// Second reset mid-run, now with the short timer
		do_reset(1'h1);
		check({rdy_n, done, rdata}, 10'h200);
		run(1'h1, 6'h10, 8'h00, 8'h00);
		wait_done();
		run(1'h1, 6'h01, 8'h00, 8'h03);
		complete_run();
	end
endmodule // phm_host_port_tb
